// >>> src/tmr_edge_sync.sv
// synchroniser and edge picker for the external count input
// assumes the pin is asynchronous; events released only on sample_en
`timescale 1ns/100ps
`default_nettype none

module tmr_edge_sync (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pin and control
    input wire logic pin,
    input wire logic edge_fall,
    input wire logic sample_en,
    // event
    output logic evt
);

    logic sync1_q, sync2_q, prev_q, pend_q;
    logic lvl, rise, pend_d;

    assign lvl = sync2_q ^ edge_fall;
    assign rise = lvl & ~prev_q;
    assign evt = sample_en & (pend_q | rise);

    always_comb begin
        pend_d = (pend_q | rise) & ~sample_en;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
            prev_q <= lvl;
            pend_q <= pend_d;
        end
    end

    property p_evt_on_sample;
        @(posedge clk) disable iff (!nrst)
        evt |-> sample_en;
    endproperty
    a_evt_on_sample: assert property (p_evt_on_sample)
        else $error("count event outside sample point");

endmodule // tmr_edge_sync

`default_nettype wire

// >>> src/tmr_pkg.sv
// constants, register map and phase states of the 8-bit timer block
// assumes one 100 MHz REF_CLK; four clocks make one instruction cycle
//
// What this block does
// - timer mode counts every instruction cycle, undivided only with assign bit one
// - source select zero picks instruction-cycle counting
// - count write inhibits counting for two cycles
// - counter mode counts chosen edge of input
// - source select one picks external count input
// - one prescaler, timer or watchdog, never both
// - assign bit zero routes prescaler to timer
// - eight ratios 1:2 to 1:256 by field
// - assign bit one gives timer 1:1 counting
// - prescaler count is hidden from software
// - count write clears prescaler when timer-owned
// - rollover sets sticky flag; software write of one to bit zero clears
// - sleep freezes the count register
// - external count sampled on Q2 and Q4
`default_nettype none

package tmr_pkg;

    // ************************************************
    // register map, byte addresses
    // ************************************************
    localparam logic [7:0] OFS_COUNT = 8'h00;
    localparam logic [7:0] OFS_OPTION = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;

    // ************************************************
    // option fields
    // ************************************************
    localparam int unsigned OPT_W = 6;
    localparam int unsigned OPT_CS_BIT = 5;
    localparam int unsigned OPT_SE_BIT = 4;
    localparam int unsigned OPT_ASSIGN_BIT = 3;
    localparam int unsigned OPT_RATIO_LSB = 0;
    localparam int unsigned OPT_RATIO_W = 3;
    localparam int unsigned IRQ_OVF_BIT = 0;

    // ************************************************
    // reset values and timing counts
    // ************************************************
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [OPT_W-1:0] RST_OPTION = 6'h00;
    localparam logic RST_FLAG = 1'b0;
    localparam logic RST_MASK = 1'b0;
    localparam logic [1:0] INHIBIT_ICYC = 2'h2;

    // instruction-cycle phases, one-hot
    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } phase_e;

    // ratio field n -> n+1 low ones
    function automatic logic [7:0] ratio_mask(
        input logic [OPT_RATIO_W-1:0] sel
    );
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++) begin
            m[i] = (i <= int'(sel));
        end
        return m;
    endfunction

endpackage

`default_nettype wire

// >>> src/tmr_prescaler.sv
// shared ripple prescaler; count is not visible to software
// assumes tick_in is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none

module tmr_prescaler #(
    parameter int unsigned W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic tick_in,
    input wire logic clear,
    input wire logic [W-1:0] mask,
    // divided pulse
    output logic tick_out
);

    logic [W-1:0] cnt_q, cnt_d;

    assign tick_out = tick_in & ((cnt_q & mask) == mask);

    always_comb begin
        cnt_d = cnt_q;
        if (clear) begin
            cnt_d = '0;
        end else if (tick_in) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    property p_clear_zero;
        @(posedge clk) disable iff (!nrst)
        clear |=> (cnt_q == '0);
    endproperty
    a_clear_zero: assert property (p_clear_zero)
        else $error("prescaler not cleared");

    property p_div_pulse;
        @(posedge clk) disable iff (!nrst)
        tick_in && !clear && ((cnt_q & mask) == mask)
            |=> (cnt_q & $past(mask)) == '0;
    endproperty
    a_div_pulse: assert property (p_div_pulse)
        else $error("prescaler did not wrap at terminal count");

endmodule // tmr_prescaler

`default_nettype wire

// >>> src/tmr_top.sv
// 8-bit timer/counter with shared prescaler, wishbone classic slave
// assumes synchronous SLEEP and WATCHDOG_TICK pulses on REF_CLK
`timescale 1ns/100ps
`default_nettype none

module tmr_top #(
    parameter int unsigned CNT_W = 8,
    parameter int unsigned PRE_W = 8
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // wishbone slave
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic WB_ACK_O,
    // count input and processor state
    input wire logic EXT_COUNT_INPUT,
    input wire logic SLEEP,
    // watchdog side
    input wire logic WATCHDOG_TICK,
    output logic WATCHDOG_PRESC_TICK,
    // interrupt
    output logic IRQ
);

    // ************************************************
    // state
    // ************************************************
    tmr_pkg::phase_e phase_q, phase_d;
    logic [CNT_W-1:0] count_q, count_d;
    logic [1:0] inhib_q, inhib_d;
    logic [tmr_pkg::OPT_W-1:0] opt_q, opt_d;
    logic flag_q, flag_d, mask_q, mask_d, irq_q, irq_d;
    logic ack_q, ack_d, wd_q, wd_d;
    logic [31:0] dat_q, dat_d;

    logic wb_req, wr0, cnt_wr, sts_wr;
    logic count_src, edge_fall, presc_assign;
    logic [tmr_pkg::OPT_RATIO_W-1:0] ratio_sel;
    logic icyc_end, sample_en, ext_evt, src_tick;
    logic presc_in, presc_clr, presc_out, tmr_tick, inc, ovf;

    // ************************************************
    // bus decode and option fields
    // ************************************************
    assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
    // writes land at the acknowledging edge
    assign wr0 = WB_CYC_I & WB_STB_I & ack_q & WB_WE_I & WB_SEL_I[0];
    assign cnt_wr = wr0 & (WB_ADR_I == tmr_pkg::OFS_COUNT);
    assign sts_wr = wr0 & (WB_ADR_I == tmr_pkg::OFS_STATUS);
    assign count_src = opt_q[tmr_pkg::OPT_CS_BIT];
    assign edge_fall = opt_q[tmr_pkg::OPT_SE_BIT];
    assign presc_assign = opt_q[tmr_pkg::OPT_ASSIGN_BIT];
    assign ratio_sel = opt_q[tmr_pkg::OPT_RATIO_LSB +: tmr_pkg::OPT_RATIO_W];

    // ************************************************
    // instruction-cycle phases
    // ************************************************
    assign icyc_end = (phase_q == tmr_pkg::PH_Q4);
    assign sample_en = (phase_q == tmr_pkg::PH_Q2) | icyc_end;

    tmr_edge_sync u_edge (
        .clk(REF_CLK),
        .nrst(NRST),
        .pin(EXT_COUNT_INPUT),
        .edge_fall(edge_fall),
        .sample_en(sample_en),
        .evt(ext_evt)
    );

    // ************************************************
    // source and prescaler routing
    // ************************************************
    // source select, frozen in sleep
    assign src_tick = SLEEP ? 1'b0 : (count_src ? ext_evt : icyc_end);
    assign presc_in = presc_assign ? WATCHDOG_TICK : src_tick;
    assign presc_clr = cnt_wr & ~presc_assign;

    tmr_prescaler #(
        .W(PRE_W)
    ) u_presc (
        .clk(REF_CLK),
        .nrst(NRST),
        .tick_in(presc_in),
        .clear(presc_clr),
        .mask(tmr_pkg::ratio_mask(ratio_sel)),
        .tick_out(presc_out)
    );

    assign tmr_tick = presc_assign ? src_tick : presc_out;
    assign inc = tmr_tick & (inhib_q == 2'h0) & ~cnt_wr;
    assign ovf = inc & (count_q == {CNT_W{1'b1}});

    // ************************************************
    // counter group
    // ************************************************
    always_comb begin
        case (phase_q)
            tmr_pkg::PH_Q1: phase_d = tmr_pkg::PH_Q2;
            tmr_pkg::PH_Q2: phase_d = tmr_pkg::PH_Q3;
            tmr_pkg::PH_Q3: phase_d = tmr_pkg::PH_Q4;
            tmr_pkg::PH_Q4: phase_d = tmr_pkg::PH_Q1;
            default: phase_d = tmr_pkg::PH_Q1;
        endcase
        inhib_d = inhib_q;
        count_d = count_q;
        if (cnt_wr) begin
            inhib_d = tmr_pkg::INHIBIT_ICYC;
        end else if (icyc_end && inhib_q != 2'h0) begin
            inhib_d = inhib_q - 2'h1;
        end
        if (cnt_wr) begin
            count_d = WB_DAT_I[CNT_W-1:0];
        end else if (inc) begin
            count_d = count_q + 1'b1;
        end
        wd_d = presc_assign & presc_out;
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            phase_q <= tmr_pkg::PH_Q1;
            inhib_q <= 2'h0;
            count_q <= tmr_pkg::RST_COUNT[CNT_W-1:0];
            wd_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            inhib_q <= inhib_d;
            count_q <= count_d;
            wd_q <= wd_d;
        end
    end

    // ************************************************
    // register group
    // ************************************************
    always_comb begin
        ack_d = wb_req;
        dat_d = 32'h0000_0000;
        opt_d = opt_q;
        mask_d = mask_q;
        if (wr0 && WB_ADR_I == tmr_pkg::OFS_OPTION) begin
            opt_d = WB_DAT_I[tmr_pkg::OPT_W-1:0];
        end
        if (wr0 && WB_ADR_I == tmr_pkg::OFS_MASK) begin
            mask_d = WB_DAT_I[tmr_pkg::IRQ_OVF_BIT];
        end
        flag_d = ovf | (flag_q & ~(sts_wr & WB_DAT_I[tmr_pkg::IRQ_OVF_BIT]));
        irq_d = flag_d & mask_d;
        if (wb_req && !WB_WE_I) begin
            case (WB_ADR_I)
                tmr_pkg::OFS_COUNT: dat_d[CNT_W-1:0] = count_q;
                tmr_pkg::OFS_OPTION: dat_d[tmr_pkg::OPT_W-1:0] = opt_q;
                tmr_pkg::OFS_STATUS: dat_d[tmr_pkg::IRQ_OVF_BIT] = flag_q;
                tmr_pkg::OFS_MASK: dat_d[tmr_pkg::IRQ_OVF_BIT] = mask_q;
                default: dat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST) begin
        if (!NRST) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
            opt_q <= tmr_pkg::RST_OPTION;
            mask_q <= tmr_pkg::RST_MASK;
            flag_q <= tmr_pkg::RST_FLAG;
            irq_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
            opt_q <= opt_d;
            mask_q <= mask_d;
            flag_q <= flag_d;
            irq_q <= irq_d;
        end
    end

    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;
    assign WATCHDOG_PRESC_TICK = wd_q;
    assign IRQ = irq_q;

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!NRST);

    sequence s_count_write;
        cnt_wr;
    endsequence

    sequence s_quiet4;
        (!cnt_wr)[*4];
    endsequence

    sequence s_quiet8;
        (!cnt_wr)[*8];
    endsequence

    property p_timer_step;
        !count_src && presc_assign && !SLEEP && icyc_end && inhib_q == 2'h0
            && !cnt_wr |=> count_q == $past(count_q) + 1'b1;
    endproperty
    a_timer_step: assert property (p_timer_step)
        else $error("timer did not step on instruction cycle");

    property p_timer_src;
        !count_src && src_tick |-> icyc_end;
    endproperty
    a_timer_src: assert property (p_timer_src)
        else $error("timer mode ticked off instruction cycle");

    property p_inhibit_hold;
        s_count_write ##1 s_quiet4 |-> inhib_q != 2'h0;
    endproperty
    a_inhibit_hold: assert property (p_inhibit_hold)
        else $error("write inhibit ended too soon");

    property p_inhibit_end;
        s_count_write ##1 s_quiet8 |=> inhib_q == 2'h0;
    endproperty
    a_inhibit_end: assert property (p_inhibit_end)
        else $error("write inhibit lasted too long");

    property p_counter_src;
        count_src && !SLEEP |-> src_tick == ext_evt;
    endproperty
    a_counter_src: assert property (p_counter_src)
        else $error("counter mode not fed by external input");

    property p_bypass;
        presc_assign && !cnt_wr && inhib_q == 2'h0 |-> inc == src_tick;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("timer not undivided with prescaler away");

    property p_wd_route;
        presc_assign && presc_out |=> WATCHDOG_PRESC_TICK;
    endproperty
    a_wd_route: assert property (p_wd_route)
        else $error("watchdog missed prescaler pulse");

    property p_overflow;
        inc && count_q == {CNT_W{1'b1}} |=> flag_q && count_q == '0;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("rollover did not set flag");

    property p_sleep_freeze;
        SLEEP && !cnt_wr |=> $stable(count_q);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze)
        else $error("count moved during sleep");

    property p_irq;
        IRQ == (flag_q && mask_q);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt level differs from flag and mask");

    property p_wd_quiet;
        !presc_assign |=> !WATCHDOG_PRESC_TICK;
    endproperty
    a_wd_quiet: assert property (p_wd_quiet)
        else $error("watchdog pulse while prescaler on timer");

    property p_count_hold;
        !inc && !cnt_wr |=> $stable(count_q);
    endproperty
    a_count_hold: assert property (p_count_hold)
        else $error("count moved without an increment");

    property p_ack_answer;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("bus request not acknowledged");

    property p_ack_pulse;
        WB_ACK_O |=> !WB_ACK_O;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("acknowledge longer than one cycle");

    property p_read_idle;
        !WB_ACK_O |-> WB_DAT_O == 32'h0000_0000;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data outside acknowledge");

endmodule // tmr_top

`default_nettype wire

// >>> test/test_eight_bit_timer_prescaler.sv
// self-checking bench for the timer with shared prescaler
// assumes tmr_pkg and tmr_top compiled first; wishbone classic master
`timescale 1ns/100ps
`default_nettype none

module test_eight_bit_timer_prescaler;
    localparam logic [7:0] ASG = 8'h01 << tmr_pkg::OPT_ASSIGN_BIT;
    localparam logic [7:0] CS = 8'h01 << tmr_pkg::OPT_CS_BIT;
    localparam logic [7:0] SE = 8'h01 << tmr_pkg::OPT_SE_BIT;
    typedef struct {logic [7:0] opt; int gap; logic [7:0] delta;} row_s;
    row_s rows [9] = '{'{ASG, 400, 8'h64}, '{8'h00, 24, 8'h03},
        '{8'h01, 48, 8'h03}, '{8'h02, 96, 8'h03}, '{8'h03, 192, 8'h03},
        '{8'h04, 384, 8'h03}, '{8'h05, 768, 8'h03},
        '{8'h06, 1536, 8'h03}, '{8'h07, 2048, 8'h02}};
    logic clk, nrst, we, cyc, stb, ack, ext_pin, sleep, wd_tick;
    logic wd_out, irq, start, busy;
    logic [7:0] adr, pin_n, tick_n, a, b;
    logic [3:0] sel;
    logic [31:0] dat_i, dat_o;
    int failures, cmp_count, t0, c0, n;
    int tick = 0;
    int wd_cnt = 0;

    tmr_top dut (.REF_CLK(clk), .NRST(nrst), .WB_ADR_I(adr),
        .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_WE_I(we), .WB_SEL_I(sel),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
        .EXT_COUNT_INPUT(ext_pin), .SLEEP(sleep), .WATCHDOG_TICK(wd_tick),
        .WATCHDOG_PRESC_TICK(wd_out), .IRQ(irq));
    tmr_far_side far (.clk(clk), .nrst(nrst), .start(start),
        .pin_n(pin_n), .tick_n(tick_n), .pin(ext_pin), .wd_tick(wd_tick),
        .busy(busy));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) tick <= tick + 1;
    always @(posedge clk) if (wd_out === 1'b1) wd_cnt <= wd_cnt + 1;

    // ************************************************
    // tasks
    // ************************************************
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic [7:0] ad, input logic w,
                      input logic [7:0] d, output logic [7:0] q);
        int k;
        k = 0;
        adr <= ad;
        we <= w;
        dat_i <= {24'h00_0000, d};
        sel <= 4'hf;
        cyc <= 1'b1;
        stb <= 1'b1;
        @(posedge clk);
        while (ack !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk);
        end
        if (k >= 20) begin
            failures++;
            wrap_up();
        end
        q = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        logic [7:0] q;
        wb(ad, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] ad, output logic [7:0] q);
        wb(ad, 1'b0, 8'h00, q);
    endtask

    task automatic wait_to(input int t);
        while (tick < t) @(posedge clk);
    endtask

    task automatic far_run(input logic [7:0] p, input logic [7:0] t);
        int k;
        pin_n <= p;
        tick_n <= t;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(posedge clk);
        k = 0;
        while (busy !== 1'b0 && k < 500) begin
            k++;
            @(posedge clk);
        end
        if (k >= 500) begin
            failures++;
            wrap_up();
        end
        repeat (12) @(posedge clk);
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        {nrst, we, cyc, stb, sleep, start} = 6'h00;
        {adr, pin_n, tick_n, sel, dat_i} = '0;
        {failures, cmp_count} = '0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(tmr_pkg::OFS_OPTION, a);
        chk8(a, 8'h00);
        rd(tmr_pkg::OFS_STATUS, a);
        chk8(a, 8'h00);
        rd(tmr_pkg::OFS_MASK, a);
        chk8(a, 8'h00);
        rd(8'h10, a);
        chk8(a, 8'h00);
        foreach (rows[i]) begin
            wr(tmr_pkg::OFS_OPTION, rows[i].opt);
            t0 = tick;
            rd(tmr_pkg::OFS_COUNT, a);
            wait_to(t0 + rows[i].gap);
            rd(tmr_pkg::OFS_COUNT, b);
            chk8(b - a, rows[i].delta);
        end
        // count write and hold-off
        wr(tmr_pkg::OFS_OPTION, ASG);
        wr(tmr_pkg::OFS_COUNT, 8'h40);
        rd(tmr_pkg::OFS_COUNT, a);
        chk8(a, 8'h40);
        t0 = tick;
        wr(tmr_pkg::OFS_COUNT, 8'h40);
        wait_to(t0 + 40);
        rd(tmr_pkg::OFS_COUNT, a);
        chk8(8'((a == 8'h47) || (a == 8'h48)), 8'h01);
        // prescaler cleared by count write
        wr(tmr_pkg::OFS_OPTION, 8'h07);
        wr(tmr_pkg::OFS_COUNT, 8'h20);
        repeat (600) @(posedge clk);
        wr(tmr_pkg::OFS_COUNT, 8'h20);
        repeat (600) @(posedge clk);
        rd(tmr_pkg::OFS_COUNT, a);
        chk8(a, 8'h20);
        // overflow, flag and interrupt
        wr(tmr_pkg::OFS_MASK, 8'h01);
        wr(tmr_pkg::OFS_OPTION, ASG);
        wr(tmr_pkg::OFS_COUNT, 8'hf0);
        n = 0;
        while (irq !== 1'b1 && n < 200) begin
            n++;
            @(posedge clk);
        end
        if (n >= 200) begin
            failures++;
            wrap_up();
        end
        chk8({7'h00, irq}, 8'h01);
        rd(tmr_pkg::OFS_STATUS, a);
        chk8(a, 8'h01);
        wr(tmr_pkg::OFS_STATUS, 8'h01);
        rd(tmr_pkg::OFS_STATUS, a);
        chk8(a, 8'h00);
        chk8({7'h00, irq}, 8'h00);
        wr(tmr_pkg::OFS_MASK, 8'h00);
        repeat (1100) @(posedge clk);
        rd(tmr_pkg::OFS_STATUS, a);
        chk8(a, 8'h01);
        chk8({7'h00, irq}, 8'h00);
        wr(tmr_pkg::OFS_STATUS, 8'h01);
        // sleep freezes the count
        sleep <= 1'b1;
        rd(tmr_pkg::OFS_COUNT, a);
        repeat (100) @(posedge clk);
        rd(tmr_pkg::OFS_COUNT, b);
        chk8(b, a);
        sleep <= 1'b0;
        // counter mode, both edges
        for (int e = 0; e < 2; e++) begin
            wr(tmr_pkg::OFS_OPTION, CS | ASG | (e[0] ? SE : 8'h00));
            repeat (20) @(posedge clk);
            rd(tmr_pkg::OFS_COUNT, a);
            far_run(8'h05, 8'h00);
            rd(tmr_pkg::OFS_COUNT, b);
            chk8(b - a, 8'h05);
        end
        // watchdog owns the prescaler, then timer owns it
        wr(tmr_pkg::OFS_OPTION, ASG | 8'h01);
        c0 = wd_cnt;
        far_run(8'h00, 8'h10);
        chk8(8'(wd_cnt - c0), 8'h04);
        wr(tmr_pkg::OFS_OPTION, 8'h01);
        c0 = wd_cnt;
        far_run(8'h00, 8'h10);
        chk8(8'(wd_cnt - c0), 8'h00);
        // mid-run reset brings registers back
        wr(tmr_pkg::OFS_COUNT, 8'h5a);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(tmr_pkg::OFS_COUNT, a);
        chk8(a, tmr_pkg::RST_COUNT);
        rd(tmr_pkg::OFS_OPTION, a);
        chk8(a, {2'b00, tmr_pkg::RST_OPTION});
        wrap_up();
    end
endmodule // test_eight_bit_timer_prescaler

`default_nettype wire

// >>> test/tmr_far_side.sv
// partner model: external count pin and watchdog clock source
// assumes start is a one-cycle pulse given while busy is low
`timescale 1ns/100ps
`default_nettype none

module tmr_far_side (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // request
    input wire logic start,
    input wire logic [7:0] pin_n,
    input wire logic [7:0] tick_n,
    // outputs
    output logic pin,
    output logic wd_tick,
    output logic busy
);
    logic [8:0] edges_q;
    logic [7:0] ticks_q;
    logic [3:0] div_q;

    // pin high and low 8 clocks each, idles low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            edges_q <= 9'h000;
            ticks_q <= 8'h00;
            div_q <= 4'h0;
            pin <= 1'b0;
            wd_tick <= 1'b0;
        end else if (start) begin
            edges_q <= {pin_n, 1'b0};
            ticks_q <= tick_n;
            div_q <= 4'h0;
            wd_tick <= 1'b0;
        end else begin
            div_q <= div_q + 4'h1;
            wd_tick <= 1'b0;
            if (div_q[2:0] == 3'h7 && edges_q != 9'h000) begin
                pin <= ~pin;
                edges_q <= edges_q - 9'h001;
            end
            // watchdog clock pulse every 4 clocks
            if (div_q[1:0] == 2'h3 && ticks_q != 8'h00) begin
                wd_tick <= 1'b1;
                ticks_q <= ticks_q - 8'h01;
            end
        end
    end

    assign busy = (edges_q != 9'h000) || (ticks_q != 8'h00);
endmodule // tmr_far_side

`default_nettype wire
